// ### logic/ata_host_ctrl.v
`include "ata_host_consts.vh"
module ata_host_ctrl (
    input wire sys_clk_i,
    input wire rst_i,
    // Command port
    input wire cmd_valid_i,
    output wire cmd_ready_o,
    input wire [1:0] cmd_op_i,
    input wire [2:0] cmd_addr_i,
    input wire cmd_cs1_i,
    input wire [15:0] cmd_len_i,
    input wire dev_reset_req_i,
    // Outgoing words (PIO write data and data-out burst)
    input wire wr_valid_i,
    output wire wr_ready_o,
    input wire [15:0] wr_data_i,
    // Incoming words
    output wire rd_valid_o,
    input wire rd_ready_i,
    output wire [15:0] rd_data_o,
    output wire done_o,
    output wire stopped_o,
    // Device pins
    output wire dev_rst_n_o,
    output wire [15:0] dd_o,
    input wire [15:0] dd_i,
    output wire dd_oe_n_o,
    output wire cs0_n_o,
    output wire cs1_n_o,
    output wire [2:0] da_o,
    output wire dmack_n_o,
    input wire dmarq_i,
    output wire diow_stop_o,
    output wire dior_hrdy_hstb_o,
    input wire iordy_drdy_dstb_i
);
    // ---------------------------------------------------------------
    // States
    // ---------------------------------------------------------------
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_SETUP = 3'h1;
    localparam [2:0] S_STROBE = 3'h2;
    localparam [2:0] S_RECOVER = 3'h3;
    localparam [2:0] S_DMA_WAIT = 3'h4;
    localparam [2:0] S_OUT = 3'h5;
    localparam [2:0] S_IN = 3'h6;
    localparam [2:0] S_END = 3'h7;

    reg [2:0] state_ff, nxt_state;
    reg [1:0] op_ff, nxt_op;
    reg [2:0] addr_ff, nxt_addr;
    reg cs1_ff, nxt_cs1;
    reg [15:0] len_ff, nxt_len;
    reg [1:0] tcnt_ff, nxt_tcnt;
    reg [15:0] dd_ff, nxt_dd;
    reg oe_n_ff, nxt_oe_n;
    reg wstb_ff, nxt_wstb;
    reg rstb_ff, nxt_rstb;
    reg stop_ff, nxt_stop;
    reg moved_ff, nxt_moved;
    reg dstb_ff;
    reg done_ff, nxt_done;
    reg stopped_ff, nxt_stopped;
    reg buf_push;
    reg [15:0] buf_word;
    reg wr_take;
    wire buf_ready;
    wire rst_busy;
    wire dstb_edge;

    function is_write;
        input [1:0] op;
        begin
            is_write = (op == `CMD_PIO_WR) || (op == `CMD_UDMA_OUT);
        end
    endfunction

    // ---------------------------------------------------------------
    // Submodules
    // ---------------------------------------------------------------
    reset_gen u_reset_gen (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .req_i(dev_reset_req_i),
        .dev_rst_n_o(dev_rst_n_o),
        .busy_o(rst_busy)
    );

    word_buf2 u_rd_buf (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .flush_i(1'b0),
        .in_valid_i(buf_push),
        .in_ready_o(buf_ready),
        .in_data_i(buf_word),
        .out_valid_o(rd_valid_o),
        .out_ready_i(rd_ready_i),
        .out_data_o(rd_data_o)
    );

    // Device strobe toggles carry one word each, both edges count
    assign dstb_edge = iordy_drdy_dstb_i ^ dstb_ff;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always @* begin
        nxt_state = state_ff;
        nxt_op = op_ff;
        nxt_addr = addr_ff;
        nxt_cs1 = cs1_ff;
        nxt_len = len_ff;
        nxt_tcnt = tcnt_ff;
        nxt_dd = dd_ff;
        nxt_oe_n = oe_n_ff;
        nxt_wstb = wstb_ff;
        nxt_rstb = rstb_ff;
        nxt_stop = stop_ff;
        nxt_moved = moved_ff;
        nxt_done = 1'b0;
        nxt_stopped = 1'b0;
        buf_push = 1'b0;
        buf_word = dd_i;
        wr_take = 1'b0;
        case (state_ff)
            S_IDLE: begin
                nxt_wstb = 1'b1;
                nxt_rstb = 1'b1;
                nxt_oe_n = 1'b1;
                if (cmd_valid_i && !rst_busy) begin
                    nxt_op = cmd_op_i;
                    nxt_addr = cmd_addr_i;
                    nxt_cs1 = cmd_cs1_i;
                    nxt_len = cmd_len_i;
                    nxt_tcnt = 2'h0;
                    if (cmd_op_i[1]) begin
                        nxt_state = S_DMA_WAIT;
                    end else begin
                        nxt_state = S_SETUP;
                    end
                end
            end
            S_SETUP: begin
                // Write data must be present before the strobe goes low
                if (op_ff == `CMD_PIO_WR) begin
                    if (wr_valid_i) begin
                        wr_take = 1'b1;
                        nxt_dd = wr_data_i;
                        nxt_oe_n = 1'b0;
                        nxt_state = S_STROBE;
                        nxt_tcnt = 2'h0;
                    end
                end else if (buf_ready) begin
                    nxt_state = S_STROBE;
                    nxt_tcnt = 2'h0;
                end
            end
            S_STROBE: begin
                if (op_ff == `CMD_PIO_WR) begin
                    nxt_wstb = 1'b0;
                end else begin
                    nxt_rstb = 1'b0;
                end
                nxt_tcnt = tcnt_ff + 2'h1;
                if (tcnt_ff == `STROBE_CYC) begin
                    nxt_wstb = 1'b1;
                    nxt_rstb = 1'b1;
                    if (op_ff == `CMD_PIO_RD) begin
                        buf_push = 1'b1;
                    end
                    nxt_state = S_RECOVER;
                end
            end
            S_RECOVER: begin
                nxt_oe_n = 1'b1;
                nxt_done = 1'b1;
                nxt_state = S_IDLE;
            end
            S_DMA_WAIT: begin
                // Write strobe idles high, STOP low, before burst start
                nxt_wstb = 1'b1;
                nxt_stop = 1'b0;
                nxt_moved = 1'b0;
                // Read strobe stays released until the acknowledge goes out
                nxt_rstb = 1'b1;
                if (dmarq_i) begin
                    nxt_oe_n = ~is_write(op_ff);
                    if (is_write(op_ff)) begin
                        nxt_state = S_OUT;
                    end else begin
                        nxt_state = S_IN;
                        nxt_rstb = 1'b0;
                    end
                end
            end
            S_OUT: begin
                // Pause while the device shows not ready or no word
                if (!iordy_drdy_dstb_i && wr_valid_i &&
                    len_ff != 16'h0000 && !stop_ff) begin
                    wr_take = 1'b1;
                    nxt_dd = wr_data_i;
                    nxt_rstb = ~rstb_ff;
                    nxt_len = len_ff - 16'h0001;
                    nxt_moved = 1'b1;
                end
                if (len_ff == 16'h0000 || !dmarq_i) begin
                    nxt_stop = 1'b1;
                    nxt_state = S_END;
                end
            end
            S_IN: begin
                if (dstb_edge && len_ff != 16'h0000) begin
                    buf_push = 1'b1;
                    nxt_len = len_ff - 16'h0001;
                    nxt_moved = 1'b1;
                end
                // Pause as the last entry fills: the pin lags a cycle
                nxt_rstb = ~buf_ready |
                           (buf_push & rd_valid_o & ~rd_ready_i);
                if (len_ff == 16'h0000 || !dmarq_i) begin
                    nxt_stop = 1'b1;
                    nxt_rstb = 1'b1;
                    nxt_state = S_END;
                end
            end
            default: begin
                // Burst ends once the device drops its request
                nxt_oe_n = 1'b1;
                if (!dmarq_i) begin
                    nxt_stop = 1'b0;
                    nxt_rstb = 1'b1;
                    nxt_done = 1'b1;
                    nxt_stopped = moved_ff;
                    nxt_state = S_IDLE;
                end
            end
        endcase
    end

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= S_IDLE;
            op_ff <= 2'h0;
            addr_ff <= 3'h0;
            cs1_ff <= 1'b0;
            len_ff <= 16'h0000;
            tcnt_ff <= 2'h0;
            dd_ff <= 16'h0000;
            oe_n_ff <= 1'b1;
            wstb_ff <= 1'b1;
            rstb_ff <= 1'b1;
            stop_ff <= 1'b0;
            moved_ff <= 1'b0;
            // Idle level of the pin, so no false edge after reset
            dstb_ff <= 1'b1;
            done_ff <= 1'b0;
            stopped_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            op_ff <= nxt_op;
            addr_ff <= nxt_addr;
            cs1_ff <= nxt_cs1;
            len_ff <= nxt_len;
            tcnt_ff <= nxt_tcnt;
            dd_ff <= nxt_dd;
            oe_n_ff <= nxt_oe_n;
            wstb_ff <= nxt_wstb;
            rstb_ff <= nxt_rstb;
            stop_ff <= nxt_stop;
            moved_ff <= nxt_moved;
            dstb_ff <= iordy_drdy_dstb_i;
            done_ff <= nxt_done;
            stopped_ff <= nxt_stopped;
        end
    end

    // ---------------------------------------------------------------
    // Pin outputs
    // ---------------------------------------------------------------
    wire in_dma;
    assign in_dma = (state_ff == S_DMA_WAIT) || (state_ff == S_OUT) ||
                    (state_ff == S_IN) || (state_ff == S_END);
    assign cmd_ready_o = (state_ff == S_IDLE) && !rst_busy;
    assign wr_ready_o = wr_take;
    assign done_o = done_ff;
    assign stopped_o = stopped_ff;
    assign dd_o = dd_ff;
    assign dd_oe_n_o = oe_n_ff;
    // Chip selects idle during bursts; address held from the command
    assign cs0_n_o = in_dma | (state_ff == S_IDLE) | cs1_ff;
    assign cs1_n_o = in_dma | (state_ff == S_IDLE) | ~cs1_ff;
    assign da_o = addr_ff;
    assign dmack_n_o = ~((state_ff == S_OUT) || (state_ff == S_IN) ||
                         (state_ff == S_END));
    // Shared conductor: write strobe until the acknowledge, STOP after
    assign diow_stop_o = dmack_n_o ? wstb_ff : stop_ff;
    assign dior_hrdy_hstb_o = rstb_ff;
endmodule // ata_host_ctrl

// ### inc/ata_host_consts.vh
`ifndef ATA_HOST_CONSTS_VH
`define ATA_HOST_CONSTS_VH
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define RESET_HOLD_US 25
// Least time, rounded up
`define RESET_HOLD_CYC \
    ((`RESET_HOLD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC 2'h3
`define PIO_SETUP_CYC 2
// ---------------------------------------------------------------
// Widths and command codes
// ---------------------------------------------------------------
`define DATA_W 16
`define CMD_PIO_WR 2'h0
`define CMD_PIO_RD 2'h1
`define CMD_UDMA_OUT 2'h2
`define CMD_UDMA_IN 2'h3
`endif

// ### logic/word_buf2.v
// ---------------------------------------------------------------
// Two-entry buffer, valid/ready on both sides
// ---------------------------------------------------------------
`include "ata_host_consts.vh"
module word_buf2 (
    input wire sys_clk_i,
    input wire rst_i,
    input wire flush_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [15:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [15:0] out_data_o
);
    reg [15:0] mem_ff [0:1];
    reg wp_ff;
    reg rp_ff;
    reg [1:0] cnt_ff;
    wire push;
    wire pop;
    assign in_ready_o = (cnt_ff != 2'h2);
    assign out_valid_o = (cnt_ff != 2'h0);
    assign out_data_o = mem_ff[rp_ff];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    always @(posedge sys_clk_i) begin
        if (push) begin
            mem_ff[wp_ff] <= in_data_i;
        end
    end
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else if (flush_i) begin
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (push) begin
                wp_ff <= ~wp_ff;
            end
            if (pop) begin
                rp_ff <= ~rp_ff;
            end
            if (push & ~pop) begin
                cnt_ff <= cnt_ff + 2'h1;
            end else if (pop & ~push) begin
                cnt_ff <= cnt_ff - 2'h1;
            end
        end
    end
endmodule // word_buf2

// ### logic/reset_gen.v
// ---------------------------------------------------------------
// Power-on reset pulse for the device line
// ---------------------------------------------------------------
`include "ata_host_consts.vh"
module reset_gen #(
    parameter [15:0] HOLD_CYC = `RESET_HOLD_CYC
) (
    input wire sys_clk_i,
    input wire rst_i,
    input wire req_i,
    output wire dev_rst_n_o,
    output wire busy_o
);
    reg [15:0] cnt_ff;
    reg rst_n_ff;
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_ff <= 16'h0000;
            rst_n_ff <= 1'b0;
        end else if (req_i) begin
            cnt_ff <= 16'h0000;
            rst_n_ff <= 1'b0;
        end else if (!rst_n_ff) begin
            // Low for HOLD_CYC whole cycles after reset release
            if (cnt_ff == HOLD_CYC - 16'h0001) begin
                rst_n_ff <= 1'b1;
            end
            cnt_ff <= cnt_ff + 16'h0001;
        end
    end
    assign dev_rst_n_o = rst_n_ff;
    assign busy_o = ~rst_n_ff;
endmodule // reset_gen

// ### test/ata_host_monitor.sv
module ata_host_monitor (
    input wire sys_clk_i,
    input wire rst_i,
    input wire cmd_ready_o,
    input wire done_o,
    input wire dev_rst_n_o,
    input wire dd_oe_n_o,
    input wire cs0_n_o,
    input wire cs1_n_o,
    input wire dmack_n_o,
    input wire dmarq_i,
    input wire diow_stop_o,
    input wire dior_hrdy_hstb_o,
    input wire iordy_drdy_dstb_i
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Cycles with the device reset line low
    // ----------------------------------------
    logic [10:0] low_cnt_ff;
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_cnt_ff <= 11'h000;
        end else if (dev_rst_n_o) begin
            low_cnt_ff <= 11'h000;
        end else if (low_cnt_ff != 11'h7FF) begin
            low_cnt_ff <= low_cnt_ff + 11'h001;
        end
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_wr_strobe;
        !diow_stop_o [*3] ##1 diow_stop_o;
    endsequence
    sequence s_rd_strobe;
        !dior_hrdy_hstb_o [*3] ##1 dior_hrdy_hstb_o;
    endsequence
    property p_rst_hold;
        $rose(dev_rst_n_o) |-> low_cnt_ff >= 11'h3E8;
    endproperty
    property p_ready_in_reset;
        !dev_rst_n_o |-> !cmd_ready_o;
    endproperty
    property p_wr_width;
        $fell(diow_stop_o) && dmack_n_o && $past(dmack_n_o) |-> s_wr_strobe;
    endproperty
    property p_rd_width;
        $fell(dior_hrdy_hstb_o) && dmack_n_o && $past(dmack_n_o)
            |-> s_rd_strobe;
    endproperty
    property p_sel_on_strobe;
        !diow_stop_o && dmack_n_o |-> !(cs0_n_o && cs1_n_o);
    endproperty
    property p_dd_on_write;
        !diow_stop_o && dmack_n_o |-> !dd_oe_n_o;
    endproperty
    property p_dd_free_on_read;
        !dior_hrdy_hstb_o && dmack_n_o |-> dd_oe_n_o;
    endproperty
    property p_idle_before_burst;
        $fell(dmack_n_o) |-> $past(diow_stop_o);
    endproperty
    property p_stop_low_at_start;
        $fell(dmack_n_o) |-> !diow_stop_o;
    endproperty
    property p_end_done;
        !dmack_n_o && diow_stop_o && !dmarq_i |-> ##[0:4] done_o;
    endproperty
    property p_hstb_ready;
        !dmack_n_o && $past(!dmack_n_o) && !dd_oe_n_o && $past(!dd_oe_n_o)
            && $changed(dior_hrdy_hstb_o) |-> $past(!iordy_drdy_dstb_i);
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("device reset released early");
    a_ready_in_reset: assert property (p_ready_in_reset)
        else $error("command taken during device reset");
    a_wr_width: assert property (p_wr_width)
        else $error("write strobe width wrong");
    a_rd_width: assert property (p_rd_width)
        else $error("read strobe width wrong");
    a_sel_on_strobe: assert property (p_sel_on_strobe)
        else $error("write strobe without chip select");
    a_dd_on_write: assert property (p_dd_on_write)
        else $error("data bus not driven on write");
    a_dd_free_on_read: assert property (p_dd_free_on_read)
        else $error("data bus driven on read");
    a_idle_before_burst: assert property (p_idle_before_burst)
        else $error("write strobe active at burst start");
    a_stop_low_at_start: assert property (p_stop_low_at_start)
        else $error("stop raised at burst start");
    a_end_done: assert property (p_end_done)
        else $error("burst end not reported");
    a_hstb_ready: assert property (p_hstb_ready)
        else $error("host strobe edge while device not ready");
endmodule // ata_host_monitor

bind ata_host_ctrl ata_host_monitor u_ata_host_monitor (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_ready_o(cmd_ready_o),
    .done_o(done_o), .dev_rst_n_o(dev_rst_n_o), .dd_oe_n_o(dd_oe_n_o),
    .cs0_n_o(cs0_n_o), .cs1_n_o(cs1_n_o), .dmack_n_o(dmack_n_o),
    .dmarq_i(dmarq_i), .diow_stop_o(diow_stop_o),
    .dior_hrdy_hstb_o(dior_hrdy_hstb_o),
    .iordy_drdy_dstb_i(iordy_drdy_dstb_i)
);

// ### test/ata_dev_model.sv
module ata_dev_model #(
    parameter [3:0] IN_WORDS = 4'h5
) (
    input wire clk_i,
    input wire dev_rst_n_i,
    input wire [15:0] host_dd_i,
    input wire host_oe_n_i,
    input wire cs0_n_i,
    input wire cs1_n_i,
    input wire [2:0] da_i,
    input wire dmack_n_i,
    input wire wstop_i,
    input wire rstb_i,
    input wire burst_i,
    input wire stall_i,
    output wire [15:0] dd_o,
    output wire dmarq_o,
    output wire rdy_stb_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Device side of the port
    // ----------------------------------------
    logic [15:0] regv_ff, dout_ff, last_ff;
    logic [15:0] mem_ff [0:15];
    logic [3:0] wa_ff, cnt_ff, sent_ff;
    logic prev_w_ff, prev_h_ff, rq_ff, rs_ff, ph_ff;
    wire in_burst = !dmack_n_i && host_oe_n_i;
    wire pio_rd = dmack_n_i && !rstb_i && !(cs0_n_i && cs1_n_i);
    // Released bus flips every cycle so a stale word never passes
    assign dd_o = pio_rd ? regv_ff : (in_burst ? dout_ff : ~last_ff);
    assign dmarq_o = rq_ff;
    assign rdy_stb_o = dmack_n_i ? 1'b1 : (host_oe_n_i ? rs_ff : stall_i);
    always @(posedge clk_i or negedge dev_rst_n_i) begin
        if (!dev_rst_n_i) begin
            regv_ff <= 16'h0000;
            wa_ff <= 4'h0;
            rq_ff <= 1'b0;
            rs_ff <= 1'b1;
            prev_w_ff <= 1'b1;
            prev_h_ff <= 1'b1;
            ph_ff <= 1'b0;
            last_ff <= 16'h0000;
        end else begin
            last_ff <= dd_o;
            prev_w_ff <= wstop_i;
            prev_h_ff <= rstb_i;
            ph_ff <= ~ph_ff;
            if (dmack_n_i && !prev_w_ff && wstop_i) begin
                regv_ff <= host_dd_i;
                wa_ff <= {!cs1_n_i, da_i};
            end
            if (burst_i) begin
                rq_ff <= 1'b1;
                cnt_ff <= 4'h0;
                sent_ff <= 4'h0;
            end else if (!dmack_n_i && wstop_i) begin
                rq_ff <= 1'b0;
            end
            if (!dmack_n_i && !host_oe_n_i && rstb_i != prev_h_ff) begin
                mem_ff[cnt_ff] <= host_dd_i;
                cnt_ff <= cnt_ff + 4'h1;
            end
            if (dmack_n_i) begin
                rs_ff <= 1'b1;
            end else if (in_burst && rq_ff && !wstop_i && !rstb_i && ph_ff
                         && sent_ff != IN_WORDS) begin
                rs_ff <= ~rs_ff;
                dout_ff <= {12'hC00, sent_ff};
                sent_ff <= sent_ff + 4'h1;
            end
        end
    end
endmodule // ata_dev_model

// ### test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_i = 1'b0, rst_i = 1'b1, cmd_valid_i = 1'b0;
    logic cmd_cs1_i = 1'b0, dev_reset_req_i = 1'b0, rd_ready_i = 1'b1;
    logic burst = 1'b0, stall = 1'b0, stop_seen = 1'b0;
    logic [1:0] cmd_op_i = 2'h0;
    logic [2:0] cmd_addr_i = 3'h0;
    logic [15:0] cmd_len_i = 16'h0000;
    logic [15:0] wq [0:7];
    logic [15:0] rq [$];
    int wi = 0, wn = 0, cyc = 0, mismatches = 0, comparisons = 0;
    wire wr_valid_i = (wi < wn);
    wire [15:0] wr_data_i = wq[wi[2:0]];
    wire cmd_ready_o, wr_ready_o, rd_valid_o, done_o, stopped_o;
    wire dev_rst_n_o, dd_oe_n_o, cs0_n_o, cs1_n_o, dmack_n_o, dmarq_i;
    wire diow_stop_o, dior_hrdy_hstb_o, iordy_drdy_dstb_i;
    wire [15:0] rd_data_o, dd_o, dd_i;
    wire [2:0] da_o;
    ata_host_ctrl u_ata_host_ctrl (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i),
        .cmd_addr_i(cmd_addr_i), .cmd_cs1_i(cmd_cs1_i),
        .cmd_len_i(cmd_len_i), .dev_reset_req_i(dev_reset_req_i),
        .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
        .wr_data_i(wr_data_i), .rd_valid_o(rd_valid_o),
        .rd_ready_i(rd_ready_i), .rd_data_o(rd_data_o), .done_o(done_o),
        .stopped_o(stopped_o), .dev_rst_n_o(dev_rst_n_o), .dd_o(dd_o),
        .dd_i(dd_i), .dd_oe_n_o(dd_oe_n_o), .cs0_n_o(cs0_n_o),
        .cs1_n_o(cs1_n_o), .da_o(da_o), .dmack_n_o(dmack_n_o),
        .dmarq_i(dmarq_i), .diow_stop_o(diow_stop_o),
        .dior_hrdy_hstb_o(dior_hrdy_hstb_o),
        .iordy_drdy_dstb_i(iordy_drdy_dstb_i)
    );
    ata_dev_model u_ata_dev_model (
        .clk_i(sys_clk_i), .dev_rst_n_i(dev_rst_n_o), .host_dd_i(dd_o),
        .host_oe_n_i(dd_oe_n_o), .cs0_n_i(cs0_n_o), .cs1_n_i(cs1_n_o),
        .da_i(da_o), .dmack_n_i(dmack_n_o), .wstop_i(diow_stop_o),
        .rstb_i(dior_hrdy_hstb_o), .burst_i(burst), .stall_i(stall),
        .dd_o(dd_i), .dmarq_o(dmarq_i), .rdy_stb_o(iordy_drdy_dstb_i)
    );
    // ----------------------------------------
    // Clock, word queues and hang guard
    // ----------------------------------------
    always #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        if (wr_valid_i && wr_ready_o === 1'b1) wi <= wi + 1;
        if (rd_valid_o === 1'b1 && rd_ready_i) rq.push_back(rd_data_o);
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            complete_run;
        end
    end
    task check(input string what, input logic [15:0] seen,
               input logic [15:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task send(input logic [1:0] op, input logic cs1, input logic [2:0] a,
              input logic [15:0] n);
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'b1;
        cmd_op_i <= op;
        cmd_cs1_i <= cs1;
        cmd_addr_i <= a;
        cmd_len_i <= n;
        @(negedge sys_clk_i);
        while (cmd_ready_o !== 1'b1) @(negedge sys_clk_i);
        @(posedge sys_clk_i);
        cmd_valid_i <= 1'b0;
    endtask
    task wait_done;
        @(negedge sys_clk_i);
        while (done_o !== 1'b1) @(negedge sys_clk_i);
        stop_seen = stopped_o;
    endtask
    task push_word(input logic [15:0] d);
        @(posedge sys_clk_i);
        wq[wn[2:0]] <= d;
        wn <= wn + 1;
    endtask
    task pulse_burst;
        @(posedge sys_clk_i);
        burst <= 1'b1;
        @(posedge sys_clk_i);
        burst <= 1'b0;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task hold_check;
        repeat (990) @(negedge sys_clk_i);
        check("dev reset low", {15'h0000, dev_rst_n_o}, 16'h0000);
        check("ready in reset", {15'h0000, cmd_ready_o}, 16'h0000);
        repeat (20) @(negedge sys_clk_i);
        check("dev reset high", {15'h0000, dev_rst_n_o}, 16'h0001);
        check("ready after", {15'h0000, cmd_ready_o}, 16'h0001);
    endtask
    task t_reset;
        hold_check;
        @(posedge sys_clk_i);
        dev_reset_req_i <= 1'b1;
        @(posedge sys_clk_i);
        dev_reset_req_i <= 1'b0;
        hold_check;
    endtask
    task t_pio(input logic cs1, input logic [2:0] a, input logic [15:0] d);
        push_word(d);
        send(2'h0, cs1, a, 16'h0000);
        wait_done;
        check("latched word", u_ata_dev_model.regv_ff, d);
        check("latched addr", {12'h000, u_ata_dev_model.wa_ff},
              {12'h000, cs1, a});
        send(2'h1, cs1, a, 16'h0000);
        wait_done;
        repeat (3) @(negedge sys_clk_i);
        check("read count", 16'(rq.size()), 16'h0001);
        if (rq.size() > 0) check("read word", rq.pop_front(), d);
    endtask
    task t_out;
        for (int i = 0; i < 4; i++) push_word(16'hB000 + 16'(i));
        send(2'h2, 1'b0, 3'h0, 16'h0004);
        pulse_burst;
        @(negedge sys_clk_i);
        while (u_ata_dev_model.cnt_ff != 4'h1) @(negedge sys_clk_i);
        @(posedge sys_clk_i);
        stall <= 1'b1;
        repeat (6) @(posedge sys_clk_i);
        check("paused count", {12'h000, u_ata_dev_model.cnt_ff}, 16'h0003);
        stall <= 1'b0;
        wait_done;
        check("out count", {12'h000, u_ata_dev_model.cnt_ff}, 16'h0004);
        for (int i = 0; i < 4; i++) begin
            check("out word", u_ata_dev_model.mem_ff[i], 16'hB000 + 16'(i));
        end
        check("out stopped", {15'h0000, stop_seen}, 16'h0001);
    endtask
    task t_in;
        @(posedge sys_clk_i);
        rd_ready_i <= 1'b0;
        send(2'h3, 1'b0, 3'h0, 16'h0005);
        pulse_burst;
        repeat (30) @(posedge sys_clk_i);
        rd_ready_i <= 1'b1;
        wait_done;
        repeat (4) @(negedge sys_clk_i);
        check("in count", 16'(rq.size()), 16'h0005);
        for (int i = 0; i < 5 && rq.size() > 0; i++) begin
            check("in word", rq.pop_front(), 16'hC000 + 16'(i));
        end
        check("in stopped", {15'h0000, stop_seen}, 16'h0001);
    endtask
    task complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_pio(1'b0, 3'h7, 16'h5A3C);
        t_pio(1'b1, 3'h6, 16'hA5C3);
        t_out;
        t_in;
        complete_run;
    end
endmodule // testbench
